// ==== hdl/rsq_defs.svh ====
// reset sequencer constants: timing counts, strap field positions, reset values
// assumes the clock runs at 200 MHz on REF_CLK_IN
`ifndef RSQ_DEFS_SVH
`define RSQ_DEFS_SVH
`define RSQ_CLK_PERIOD_PS 5000
`define RSQ_RST_OUT_DELAY_US 1500
`define RSQ_RST_OUT_CYCLES ((`RSQ_RST_OUT_DELAY_US * 1000000 + `RSQ_CLK_PERIOD_PS - 1) / `RSQ_CLK_PERIOD_PS)
`define RSQ_ASYNC_MIN_PULSE_CYCLES 2
`define RSQ_RATIO_LSB 0
`define RSQ_RATIO_W 3
`define RSQ_RATIO_RESET 3'h0
`define RSQ_STRAP_W 8
`define RSQ_STRAP_RESET 8'h00
`define RSQ_ASYNC_W 4
`define RSQ_CNT_W 20
`endif

// ==== hdl/rsq_pkg.sv ====
// reset sequencer types
// assumes rsq_defs.svh is on the include path
`default_nettype none
`include "rsq_defs.svh"
package rsq_pkg;
	typedef enum logic [1:0] {RSQ_HOLD, RSQ_COUNT, RSQ_RUN} rsq_state_t;
	typedef logic [`RSQ_RATIO_W-1:0] rsq_ratio_t;
endpackage : rsq_pkg
`default_nettype wire

// ==== hdl/rsq_clk_div.sv ====
// core clock enable generator dividing by the latched ratio, with ratio 0 dividing by 1 like ratio 1
// assumes ratio is held stable outside reset
`timescale 1ns/1ps
`default_nettype none
`include "rsq_defs.svh"
module rsq_clk_div
	import rsq_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire rsq_ratio_t ratio_in,
	output logic tick_out
);
	rsq_ratio_t cnt_r;
	rsq_ratio_t cnt_nxt;
	wire logic wrap = (ratio_in == `RSQ_RATIO_RESET) || (cnt_r >= ratio_in - 3'h1);
	assign cnt_nxt = wrap ? 3'h0 : cnt_r + 3'h1;
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cnt_r <= 3'h0;
			tick_out <= 1'b0;
		end else if (ce_in) begin
			cnt_r <= cnt_nxt;
			tick_out <= wrap;
		end
	end
endmodule : rsq_clk_div
`default_nettype wire

// ==== hdl/rsq_top.sv ====
// reset sequencing, strap latching, core clock ratio and async input qualification
// assumes one 200 MHz clock; async request pins enter through two-flop synchronisers
`timescale 1ns/1ps
`default_nettype none
`include "rsq_defs.svh"
module rsq_top
	import rsq_pkg::*;
#(
	parameter int RST_OUT_CYCLES = `RSQ_RST_OUT_CYCLES
)
(
	// clock, reset, enable
	input wire logic REF_CLK_IN,
	input wire logic SYS_RST_IN,
	input wire logic CLK_EN_IN,
	// board reset request and straps
	input wire logic RESET_REQ_IN,
	input wire logic [`RSQ_STRAP_W-1:0] STRAP_IN,
	input wire logic [`RSQ_RATIO_W-1:0] CLOCK_RATIO_STRAP_IN,
	// asynchronous request pins
	input wire logic [`RSQ_ASYNC_W-1:0] EXT_INTERRUPT_REQ_IN,
	input wire logic [`RSQ_ASYNC_W-1:0] EXT_DMA_REQ_IN,
	input wire logic [`RSQ_ASYNC_W-1:0] GENERAL_PURPOSE_PIN_IN,
	// timer expired pin
	input wire logic TIMER_ZERO_EXPIRED_IN,
	output logic TIMER_ZERO_EXPIRED_OUT,
	output logic TIMER_ZERO_EXPIRED_OE_N_OUT,
	input wire logic TIMER_EXPIRE_EVENT_IN,
	// reset done and latched configuration
	output logic RESET_DONE_N_OUT,
	output logic [`RSQ_STRAP_W-1:0] STRAP_OUT,
	output logic [`RSQ_RATIO_W-1:0] CLOCK_RATIO_OUT,
	output logic TIMER_STRAP_OUT,
	output logic CORE_INSTR_CLOCK_TICK_OUT,
	// qualified requests
	output logic [`RSQ_ASYNC_W-1:0] IRQ_LEVEL_OUT,
	output logic [`RSQ_ASYNC_W-1:0] DMA_LEVEL_OUT,
	output logic [`RSQ_ASYNC_W-1:0] GP_LEVEL_OUT
);
	localparam int NSYNC = 3 * `RSQ_ASYNC_W;
	rsq_state_t state_r;
	rsq_state_t state_nxt;
	logic [`RSQ_CNT_W-1:0] cnt_r;
	logic [NSYNC-1:0] meta_r;
	logic [NSYNC-1:0] sync_r;
	logic [NSYNC-1:0] stab_r;
	logic [NSYNC-1:0] level_r;
	wire logic [NSYNC-1:0] raw_in = {GENERAL_PURPOSE_PIN_IN, EXT_DMA_REQ_IN, EXT_INTERRUPT_REQ_IN};
	wire logic in_reset = SYS_RST_IN || RESET_REQ_IN;
	wire logic count_done = (cnt_r >= RST_OUT_CYCLES[`RSQ_CNT_W-1:0] - 20'h00001);

	// ****************************************
	// release decode
	// ****************************************
	function automatic logic released(input rsq_state_t st, input logic req);
		released = (st == RSQ_HOLD) && !req;
	endfunction : released

	wire logic release_edge = released(state_r, RESET_REQ_IN);
	wire logic core_tick;

	// ****************************************
	// reset sequence state
	// ****************************************
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			RSQ_HOLD: if (released(state_r, RESET_REQ_IN)) state_nxt = RSQ_COUNT;
			RSQ_COUNT: if (count_done) state_nxt = RSQ_RUN;
			RSQ_RUN: state_nxt = RSQ_RUN;
			default: state_nxt = RSQ_HOLD;
		endcase
		if (RESET_REQ_IN) state_nxt = RSQ_HOLD;
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (SYS_RST_IN) begin
			state_r <= RSQ_HOLD;
			cnt_r <= 20'h00000;
			RESET_DONE_N_OUT <= 1'b0;
		end else if (CLK_EN_IN) begin
			state_r <= state_nxt;
			cnt_r <= (state_nxt == RSQ_COUNT && state_r == RSQ_COUNT) ? cnt_r + 20'h00001 : 20'h00000;
			RESET_DONE_N_OUT <= (state_nxt == RSQ_RUN);
		end
	end

	// ****************************************
	// strap latch at release
	// ****************************************
	always_ff @(posedge REF_CLK_IN) begin
		if (SYS_RST_IN) begin
			STRAP_OUT <= `RSQ_STRAP_RESET;
			CLOCK_RATIO_OUT <= `RSQ_RATIO_RESET;
			TIMER_STRAP_OUT <= 1'b0;
		end else if (CLK_EN_IN && release_edge) begin
			STRAP_OUT <= STRAP_IN;
			CLOCK_RATIO_OUT <= CLOCK_RATIO_STRAP_IN;
			TIMER_STRAP_OUT <= TIMER_ZERO_EXPIRED_IN;
		end
	end

	// ****************************************
	// timer expired pin
	// ****************************************
	always_ff @(posedge REF_CLK_IN) begin
		if (SYS_RST_IN) begin
			TIMER_ZERO_EXPIRED_OUT <= 1'b0;
		end else if (CLK_EN_IN) begin
			TIMER_ZERO_EXPIRED_OUT <= in_reset ? 1'b0 : TIMER_EXPIRE_EVENT_IN;
		end
	end

	// pin released to its pull-down while in reset
	always_ff @(posedge REF_CLK_IN) begin
		if (SYS_RST_IN) begin
			TIMER_ZERO_EXPIRED_OE_N_OUT <= 1'b1;
		end else if (CLK_EN_IN) begin
			TIMER_ZERO_EXPIRED_OE_N_OUT <= in_reset;
		end
	end

	// ****************************************
	// core clock divider
	// ****************************************
	rsq_clk_div u_div (
		.clk_in(REF_CLK_IN),
		.rst_in(in_reset),
		.ce_in(CLK_EN_IN),
		.ratio_in(CLOCK_RATIO_OUT),
		.tick_out(core_tick)
	);

	always_ff @(posedge REF_CLK_IN) begin
		if (SYS_RST_IN) begin
			CORE_INSTR_CLOCK_TICK_OUT <= 1'b0;
		end else if (CLK_EN_IN) begin
			CORE_INSTR_CLOCK_TICK_OUT <= core_tick;
		end
	end

	// ****************************************
	// async input qualification
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge REF_CLK_IN) begin
				if (SYS_RST_IN) begin
					meta_r[gi] <= 1'b0;
					sync_r[gi] <= 1'b0;
					stab_r[gi] <= 1'b0;
					level_r[gi] <= 1'b0;
				end else if (CLK_EN_IN) begin
					meta_r[gi] <= raw_in[gi];
					sync_r[gi] <= meta_r[gi];
					stab_r[gi] <= sync_r[gi];
					if (sync_r[gi] == stab_r[gi]) begin
						level_r[gi] <= stab_r[gi];
					end
				end
			end
		end
	endgenerate

	// ****************************************
	// interrupt request levels
	// ****************************************
	always_ff @(posedge REF_CLK_IN) begin
		if (SYS_RST_IN) begin
			IRQ_LEVEL_OUT <= 4'h0;
		end else if (CLK_EN_IN) begin
			IRQ_LEVEL_OUT <= level_r[3:0];
		end
	end

	// ****************************************
	// dma request levels
	// ****************************************
	always_ff @(posedge REF_CLK_IN) begin
		if (SYS_RST_IN) begin
			DMA_LEVEL_OUT <= 4'h0;
		end else if (CLK_EN_IN) begin
			DMA_LEVEL_OUT <= level_r[7:4];
		end
	end

	// ****************************************
	// general purpose pin levels
	// ****************************************
	always_ff @(posedge REF_CLK_IN) begin
		if (SYS_RST_IN) begin
			GP_LEVEL_OUT <= 4'h0;
		end else if (CLK_EN_IN) begin
			GP_LEVEL_OUT <= level_r[11:8];
		end
	end
endmodule : rsq_top
`default_nettype wire

// ==== test/rsq_chk.sv ====
// checker for the reset sequencer top ports
// assumes one clock domain and a synchronous active high reset
`timescale 1ns/1ps
`default_nettype none
module rsq_chk #(parameter int RST_OUT_CYCLES = 20) (
	input wire logic REF_CLK_IN, SYS_RST_IN, RESET_REQ_IN, RESET_DONE_N_OUT,
	input wire logic [7:0] STRAP_IN, STRAP_OUT,
	input wire logic [2:0] CLOCK_RATIO_STRAP_IN, CLOCK_RATIO_OUT,
	input wire logic [3:0] EXT_INTERRUPT_REQ_IN, EXT_DMA_REQ_IN, IRQ_LEVEL_OUT, DMA_LEVEL_OUT,
	input wire logic TIMER_ZERO_EXPIRED_OUT, TIMER_ZERO_EXPIRED_OE_N_OUT, CORE_INSTR_CLOCK_TICK_OUT
);
	logic [19:0] low_r;
	logic [3:0] gap_r;
	default clocking @(posedge REF_CLK_IN); endclocking
	default disable iff (SYS_RST_IN);
	always_ff @(posedge REF_CLK_IN) begin
		low_r <= (SYS_RST_IN || RESET_REQ_IN) ? 20'h0 : low_r + 20'h1;
		if (SYS_RST_IN || !RESET_DONE_N_OUT) gap_r <= 4'h0;
		else if (CORE_INSTR_CLOCK_TICK_OUT) gap_r <= 4'h1;
		else if (gap_r != 4'h0 && gap_r != 4'hF) gap_r <= gap_r + 4'h1;
	end
	sequence s_quiet;
		$stable({EXT_INTERRUPT_REQ_IN, EXT_DMA_REQ_IN})[*8];
	endsequence
	a_done_not_early: assert property ($rose(RESET_DONE_N_OUT) |-> low_r > RST_OUT_CYCLES)
		else $error("reset done released early");
	a_done_not_late: assert property (low_r == RST_OUT_CYCLES + 4 |-> RESET_DONE_N_OUT)
		else $error("reset done released late");
	a_strap_latch: assert property ($fell(RESET_REQ_IN) |=> STRAP_OUT == $past(STRAP_IN)
		&& CLOCK_RATIO_OUT == $past(CLOCK_RATIO_STRAP_IN)) else $error("straps not latched");
	a_strap_hold: assert property (RESET_DONE_N_OUT && $past(RESET_DONE_N_OUT) |-> $stable(STRAP_OUT))
		else $error("straps moved while running");
	a_tick_gap: assert property (CORE_INSTR_CLOCK_TICK_OUT && gap_r != 4'h0 |-> gap_r ==
		((CLOCK_RATIO_OUT < 3'h2) ? 4'h1 : {1'b0, CLOCK_RATIO_OUT})) else $error("tick gap wrong");
	a_pin_released: assert property (RESET_REQ_IN |=> TIMER_ZERO_EXPIRED_OE_N_OUT
		&& !TIMER_ZERO_EXPIRED_OUT) else $error("timer pin driven in reset");
	a_req_follow: assert property (s_quiet |-> {IRQ_LEVEL_OUT, DMA_LEVEL_OUT} ==
		{EXT_INTERRUPT_REQ_IN, EXT_DMA_REQ_IN}) else $error("request level not followed");
endmodule : rsq_chk
bind rsq_top rsq_chk #(.RST_OUT_CYCLES(RST_OUT_CYCLES)) u_chk (.*);
`default_nettype wire

// ==== test/rsq_board.sv ====
// board supervisor model: reset request, straps, timer pin pull-down
// assumes inputs change on the falling clock edge
`timescale 1ns/1ps
`default_nettype none
module rsq_board (
	input wire logic clk_in, oe_n_in, drv_in,
	output logic req_out = 1'b1,
	output logic [7:0] strap_out = 8'h00,
	output logic [2:0] ratio_out = 3'h0,
	output wire logic pin_out
);
	assign pin_out = oe_n_in ? 1'b0 : drv_in;
	task automatic cycle(input logic [7:0] s, input logic [2:0] r);
		@(negedge clk_in);
		req_out = 1'b1;
		strap_out = s;
		ratio_out = r;
		repeat (100) @(negedge clk_in);
		req_out = 1'b0;
	endtask : cycle
endmodule : rsq_board
`default_nettype wire

// ==== test/tb.sv ====
// self-checking bench for the reset sequencer
// assumes rsq_defs.svh on the include path; done count shortened to 20
`timescale 1ns/1ps
`default_nettype none
module tb;
	import rsq_pkg::*;
	logic REF_CLK_IN = 1'b0, SYS_RST_IN = 1'b1, CLK_EN_IN = 1'b1, TIMER_EXPIRE_EVENT_IN = 1'b0;
	logic [3:0] EXT_INTERRUPT_REQ_IN = 4'h0, EXT_DMA_REQ_IN = 4'h0;
	wire logic RESET_REQ_IN, TIMER_ZERO_EXPIRED_IN, TIMER_ZERO_EXPIRED_OUT, TIMER_STRAP_OUT;
	wire logic TIMER_ZERO_EXPIRED_OE_N_OUT, RESET_DONE_N_OUT, CORE_INSTR_CLOCK_TICK_OUT;
	wire logic [7:0] STRAP_IN, STRAP_OUT;
	wire logic [2:0] CLOCK_RATIO_STRAP_IN, CLOCK_RATIO_OUT;
	wire logic [3:0] GENERAL_PURPOSE_PIN_IN, IRQ_LEVEL_OUT, DMA_LEVEL_OUT, GP_LEVEL_OUT;
	int bad_count = 0;
	int tests_run = 0;
	assign GENERAL_PURPOSE_PIN_IN = ~EXT_INTERRUPT_REQ_IN;
	always #2.5 REF_CLK_IN = ~REF_CLK_IN;
	rsq_board brd (.clk_in(REF_CLK_IN), .oe_n_in(TIMER_ZERO_EXPIRED_OE_N_OUT),
		.drv_in(TIMER_ZERO_EXPIRED_OUT), .req_out(RESET_REQ_IN), .strap_out(STRAP_IN),
		.ratio_out(CLOCK_RATIO_STRAP_IN), .pin_out(TIMER_ZERO_EXPIRED_IN));
	rsq_top #(.RST_OUT_CYCLES(20)) dut (.*);
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			bad_count++;
			$display("Error %s expected %0h seen %0h", n, e, s);
		end
	endtask : chk
	task automatic t_ratio;
		int n;
		int g;
		for (int r = 0; r < 8; r++) begin
			brd.cycle(8'hA5 ^ 8'(r), 3'(r));
			n = 0;
			while (RESET_DONE_N_OUT !== 1'b1 && n < 40) begin @(negedge REF_CLK_IN); n++; end
			chk("done delay", 32'(n >= 20 && n <= 23), 1);
			chk("strap", STRAP_OUT, 8'hA5 ^ 8'(r));
			chk("ratio", CLOCK_RATIO_OUT, r);
			chk("timer strap", TIMER_STRAP_OUT, 0);
			g = 0;
			while (CORE_INSTR_CLOCK_TICK_OUT !== 1'b1 && g < 10) begin @(negedge REF_CLK_IN); g++; end
			g = 0;
			do begin @(negedge REF_CLK_IN); g++; end while (CORE_INSTR_CLOCK_TICK_OUT !== 1'b1 && g < 10);
			chk("tick gap", g, (r < 2) ? 1 : r);
			brd.strap_out = 8'h3C;
			repeat (3) @(negedge REF_CLK_IN);
			chk("strap held", STRAP_OUT, 8'hA5 ^ 8'(r));
		end
		$display("ratio test ended");
	endtask : t_ratio
	task automatic t_restart;
		brd.cycle(8'h11, 3'h2);
		repeat (15) @(negedge REF_CLK_IN);
		brd.req_out = 1'b1;
		repeat (3) @(negedge REF_CLK_IN);
		chk("done in restart", RESET_DONE_N_OUT, 0);
		chk("pin released", TIMER_ZERO_EXPIRED_OE_N_OUT, 1);
		brd.req_out = 1'b0;
		repeat (19) @(negedge REF_CLK_IN);
		chk("done early", RESET_DONE_N_OUT, 0);
		repeat (5) @(negedge REF_CLK_IN);
		chk("done late", RESET_DONE_N_OUT, 1);
		$display("restart test ended");
	endtask : t_restart
	task automatic t_async;
		@(negedge REF_CLK_IN);
		TIMER_EXPIRE_EVENT_IN = 1'b1;
		repeat (2) @(negedge REF_CLK_IN);
		chk("timer pin", {TIMER_ZERO_EXPIRED_OE_N_OUT, TIMER_ZERO_EXPIRED_OUT}, 2'b01);
		for (int v = 0; v < 3; v++) begin
			@(negedge REF_CLK_IN);
			#1.3 EXT_INTERRUPT_REQ_IN = 4'hA ^ 4'(v * 15);
			EXT_DMA_REQ_IN = ~EXT_INTERRUPT_REQ_IN;
			repeat (8) @(negedge REF_CLK_IN);
			chk("irq level", IRQ_LEVEL_OUT, 4'hA ^ 4'(v * 15));
			chk("dma level", DMA_LEVEL_OUT, 4'h5 ^ 4'(v * 15));
			chk("gp level", GP_LEVEL_OUT, 4'h5 ^ 4'(v * 15));
		end
		$display("async test ended");
	endtask : t_async
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test
	initial begin
		#20000;
		bad_count++;
		end_of_test();
	end
	initial begin
		repeat (4) @(negedge REF_CLK_IN);
		SYS_RST_IN = 1'b0;
		t_ratio();
		t_restart();
		t_async();
		end_of_test();
	end
endmodule : tb
`default_nettype wire
